// *** hw/belrs_pkg.sv ***
package belrs_pkg;

    // ------------------------------------------------------------------
    // bus and register geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W    = 9;
    localparam int DATA_W    = 32;
    localparam int FIELD_W   = 14;
    localparam int NUM_COEFF = 25;
    localparam int NUM_LOC   = 24;
    localparam int CNT_W     = 5;
    localparam int IDX_W     = 5;

    localparam logic [ADDR_W-1:0] OFF_CONFIG      = 9'h000;
    localparam logic [ADDR_W-1:0] OFF_PRIMITIVE   = 9'h004;
    localparam logic [ADDR_W-1:0] OFF_START       = 9'h008;
    localparam logic [ADDR_W-1:0] OFF_STOP        = 9'h00c;
    localparam logic [ADDR_W-1:0] OFF_STATE       = 9'h010;
    localparam logic [ADDR_W-1:0] OFF_IRQ_SET     = 9'h014;
    localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR   = 9'h018;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK    = 9'h01c;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS  = 9'h020;
    localparam logic [ADDR_W-1:0] OFF_COEFF_FIRST = 9'h028;
    localparam logic [ADDR_W-1:0] OFF_COEFF_LAST  = 9'h088;
    localparam logic [ADDR_W-1:0] OFF_LOC_FIRST   = 9'h08c;
    localparam logic [ADDR_W-1:0] OFF_LOC_LAST    = 9'h0e4;
    localparam logic [ADDR_W-1:0] ADDR_WORD_MASK  = 9'h1fc;

    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int CFG_SECTOR_BIT = 0;
    localparam int CFG_EXPECTED_ERROR_NUMBER_LSB = 16;
    localparam int STATE_BUSY_BIT = 0;
    localparam int IRQ_DONE_BIT   = 0;
    localparam int STOP_BIT       = 0;
    localparam int ISR_CNT_LSB    = 8;

    localparam logic [DATA_W-1:0]  RESET_WORD  = 32'h0000_0000;
    localparam logic [FIELD_W-1:0] RESET_FIELD = 14'h0000;
    localparam logic [CNT_W-1:0]   RESET_CNT   = 5'h00;

    // ------------------------------------------------------------------
    // finite fields, search limit, state and bus request types
    // ------------------------------------------------------------------
    localparam logic [15:0]        PRIM_SMALL   = 16'h201b;
    localparam logic [15:0]        PRIM_LARGE   = 16'h4443;
    localparam logic [FIELD_W-1:0] REDUCE_SMALL = 14'h001b;
    localparam logic [FIELD_W-1:0] REDUCE_LARGE = 14'h0443;
    localparam logic [FIELD_W-1:0] ORDER_SMALL  = 14'h1fff;
    localparam logic [FIELD_W-1:0] ORDER_LARGE  = 14'h3fff;
    localparam logic [CNT_W-1:0]   LOC_FULL     = 5'h18;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_RUN  = 1'b1
    } belrs_state_type;

    typedef struct packed {
        logic              cyc;
        logic              stb;
        logic              we;
        logic [3:0]        sel;
        logic [ADDR_W-1:0] adr;
        logic [DATA_W-1:0] dat;
    } belrs_wbreq_type;

endpackage : belrs_pkg

// *** hw/belrs_root_search.sv ***
module belrs_root_search (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst,
    // wishbone slave
    input  wire belrs_pkg::belrs_wbreq_type wbReq,
    output logic [belrs_pkg::DATA_W-1:0]   wbDatOut,
    output logic                           wbAck,
    // interrupt
    output logic                           irq
);
    import belrs_pkg::*;

    // ------------------------------------------------------------------
    // field arithmetic
    // ------------------------------------------------------------------
    function automatic logic [FIELD_W-1:0] mulAlpha(input logic [FIELD_W-1:0] val,
                                                    input logic             big);
        logic [FIELD_W-1:0] shifted;
        shifted = {val[FIELD_W-2:0], 1'b0};
        if (big) begin
            mulAlpha = val[13] ? (shifted ^ REDUCE_LARGE) : shifted;
        end else begin
            mulAlpha = val[12] ? ((shifted & ORDER_SMALL) ^ REDUCE_SMALL) : (shifted & ORDER_SMALL);
        end
    endfunction : mulAlpha

    // multiply by alpha^n, n up to the highest degree
    function automatic logic [FIELD_W-1:0] mulAlphaPow(input logic [FIELD_W-1:0] val,
                                                       input int               n,
                                                       input logic             big);
        logic [FIELD_W-1:0] acc;
        acc = val;
        for (int k = 0; k < NUM_COEFF - 1; k++) begin
            if (k < n) begin
                acc = mulAlpha(acc, big);
            end
        end
        mulAlphaPow = acc;
    endfunction : mulAlphaPow

    function automatic logic [DATA_W-1:0] laneMerge(input logic [DATA_W-1:0] old,
                                                    input logic [DATA_W-1:0] nw,
                                                    input logic [3:0]        sel);
        logic [DATA_W-1:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        laneMerge = res;
    endfunction : laneMerge

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    belrs_state_type    state_q;
    logic               ack_q;
    logic [DATA_W-1:0]  datOut_q;
    logic               sectorBig_q;
    logic [CNT_W-1:0]   expected_error_number_q;
    logic [FIELD_W-1:0] testCount_q;
    logic               done_q;
    logic               mask_q;
    logic [CNT_W-1:0]   found_q;
    logic [FIELD_W-1:0] step_q;
    logic [FIELD_W-1:0] coeff_q [NUM_COEFF];
    logic [FIELD_W-1:0] term_q  [NUM_COEFF];
    logic [FIELD_W-1:0] loc_q   [NUM_LOC];

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    wire                busOn     = wbReq.cyc & wbReq.stb;
    // writes land on the edge where the master sees ack, not before
    wire                wrCommit  = busOn & ack_q & wbReq.we;
    wire [ADDR_W-1:0]   adr       = wbReq.adr & ADDR_WORD_MASK;
    wire                hitCfg    = (adr == OFF_CONFIG);
    wire                hitPrim   = (adr == OFF_PRIMITIVE);
    wire                hitStart  = (adr == OFF_START);
    wire                hitStop   = (adr == OFF_STOP);
    wire                hitState  = (adr == OFF_STATE);
    wire                hitIrqSet = (adr == OFF_IRQ_SET);
    wire                hitIrqClr = (adr == OFF_IRQ_CLEAR);
    wire                hitMask   = (adr == OFF_IRQ_MASK);
    wire                hitStatus = (adr == OFF_IRQ_STATUS);
    wire                hitCoeff  = (adr >= OFF_COEFF_FIRST) && (adr <= OFF_COEFF_LAST);
    wire                hitLoc    = (adr >= OFF_LOC_FIRST) && (adr <= OFF_LOC_LAST);
    wire [ADDR_W-1:0]   coeffOff  = adr - OFF_COEFF_FIRST;
    wire [ADDR_W-1:0]   locOff    = adr - OFF_LOC_FIRST;
    wire [IDX_W-1:0]    coeffIdx  = coeffOff[IDX_W+1:2];
    wire [IDX_W-1:0]    locIdx    = locOff[IDX_W+1:2];

    wire                running   = (state_q == ST_RUN);
    wire                startWrite = wrCommit & hitStart & ~running;
    wire                stopWrite  = wrCommit & hitStop;
    wire [FIELD_W-1:0]  fieldMask  = sectorBig_q ? ORDER_LARGE : ORDER_SMALL;
    wire [15:0]         primWord   = sectorBig_q ? PRIM_LARGE : PRIM_SMALL;

    // ------------------------------------------------------------------
    // root evaluation
    // ------------------------------------------------------------------
    logic [FIELD_W-1:0] evalSum;
    always_comb begin
        evalSum = RESET_FIELD;
        for (int i = 0; i < NUM_COEFF; i++) begin
            evalSum = evalSum ^ term_q[i];
        end
    end

    // zero expected_error_number means search for the full set of positions
    wire [CNT_W-1:0]    foundLimit = ((expected_error_number_q == RESET_CNT) || (expected_error_number_q > LOC_FULL)) ? LOC_FULL
                                                                                       : expected_error_number_q;
    wire                inRange    = (step_q < fieldMask);
    wire                rootHit    = running & (evalSum == RESET_FIELD) & inRange & (found_q < foundLimit);
    wire [FIELD_W-1:0]  stepNext   = step_q + 14'h0001;
    wire                lastStep   = (stepNext >= testCount_q);
    wire [CNT_W-1:0]    foundNext  = found_q + {{(CNT_W-1){1'b0}}, rootHit};
    wire                finish     = running & ~stopWrite & (lastStep | (foundNext == foundLimit));

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    wire [DATA_W-1:0]   rdCfg     = {11'h000, expected_error_number_q, 15'h0000, sectorBig_q};
    wire [DATA_W-1:0]   rdStart   = {18'h00000, testCount_q};
    wire [DATA_W-1:0]   rdState   = {31'h00000000, running};
    wire [DATA_W-1:0]   rdMask    = {31'h00000000, mask_q};
    wire [DATA_W-1:0]   rdStatus  = {19'h00000, found_q, 7'h00, done_q};
    wire [DATA_W-1:0]   rdCoeff   = {18'h00000, coeff_q[coeffIdx]};
    wire [DATA_W-1:0]   rdLoc     = {18'h00000, loc_q[locIdx]};
    // unmapped and write-only addresses answer with zero
    wire [DATA_W-1:0]   rdData    = hitCfg    ? rdCfg :
                                    hitPrim   ? {16'h0000, primWord} :
                                    hitStart  ? rdStart :
                                    hitState  ? rdState :
                                    hitMask   ? rdMask :
                                    hitStatus ? rdStatus :
                                    hitCoeff  ? rdCoeff :
                                    hitLoc    ? rdLoc : RESET_WORD;

    // ------------------------------------------------------------------
    // bus slave: one wait state, ack for exactly one cycle
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_q    <= 1'b0;
            datOut_q <= RESET_WORD;
        end else begin
            ack_q    <= busOn & ~ack_q;
            datOut_q <= rdData;
        end
    end

    assign wbAck    = ack_q;
    assign wbDatOut = datOut_q;
    assign irq      = done_q & mask_q;

    // ------------------------------------------------------------------
    // configuration and interrupt control
    // ------------------------------------------------------------------
    wire [DATA_W-1:0]   cfgMerged   = laneMerge(rdCfg, wbReq.dat, wbReq.sel);
    wire [DATA_W-1:0]   startMerged = laneMerge(rdStart, wbReq.dat, wbReq.sel);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sectorBig_q <= 1'b0;
            expected_error_number_q    <= RESET_CNT;
            testCount_q <= RESET_FIELD;
            mask_q      <= 1'b0;
        end else begin
            // config is frozen while busy so the field cannot change mid-search
            if (wrCommit & hitCfg & ~running) begin
                sectorBig_q <= cfgMerged[CFG_SECTOR_BIT];
                expected_error_number_q    <= cfgMerged[CFG_EXPECTED_ERROR_NUMBER_LSB +: CNT_W];
            end
            if (startWrite) begin
                testCount_q <= startMerged[FIELD_W-1:0];
            end
            if (wrCommit & hitIrqSet & wbReq.dat[IRQ_DONE_BIT]) begin
                mask_q <= 1'b1;
            end else if (wrCommit & hitIrqClr & wbReq.dat[IRQ_DONE_BIT]) begin
                mask_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // coefficients
    // ------------------------------------------------------------------
    wire [DATA_W-1:0]   coeffMerged = laneMerge(rdCoeff, wbReq.dat, wbReq.sel);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_COEFF; i++) begin
                coeff_q[i] <= RESET_FIELD;
            end
        end else if (wrCommit & hitCoeff & ~running) begin
            coeff_q[coeffIdx] <= coeffMerged[FIELD_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // search engine: one field element per clock
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            step_q  <= RESET_FIELD;
            found_q <= RESET_CNT;
            for (int i = 0; i < NUM_COEFF; i++) begin
                term_q[i] <= RESET_FIELD;
            end
        end else if (startWrite) begin
            state_q <= ST_RUN;
            step_q  <= RESET_FIELD;
            found_q <= RESET_CNT;
            for (int i = 0; i < NUM_COEFF; i++) begin
                term_q[i] <= coeff_q[i] & fieldMask;
            end
        end else if (running) begin
            found_q <= foundNext;
            step_q  <= stepNext;
            for (int i = 0; i < NUM_COEFF; i++) begin
                term_q[i] <= mulAlphaPow(term_q[i], i, sectorBig_q);
            end
            if (stopWrite | finish) begin
                state_q <= ST_IDLE;
            end
        end
    end

    // ------------------------------------------------------------------
    // completion flag and error positions
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            done_q <= 1'b0;
            for (int i = 0; i < NUM_LOC; i++) begin
                loc_q[i] <= RESET_FIELD;
            end
        end else begin
            // start is refused while running, so set and clear never meet
            done_q <= finish | (done_q & ~startWrite);
            if (startWrite) begin
                for (int i = 0; i < NUM_LOC; i++) begin
                    loc_q[i] <= RESET_FIELD;
                end
            end else if (rootHit) begin
                loc_q[found_q] <= step_q;
            end
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_start_runs: assert property (@(posedge clk) disable iff (rst)
        startWrite |=> running && step_q == RESET_FIELD && found_q == RESET_CNT)
        else $error("search did not start on start write");

    a_stop_aborts: assert property (@(posedge clk) disable iff (rst)
        (running && stopWrite) |=> !running && $stable(done_q))
        else $error("stop write did not abort quietly");

    a_busy_through: assert property (@(posedge clk) disable iff (rst)
        (running && !finish && !stopWrite) |=> running && step_q == $past(step_q) + 14'h0001)
        else $error("busy dropped before the search ended");

    a_done_irq: assert property (@(posedge clk) disable iff (rst)
        (finish && mask_q && !(wrCommit && hitIrqClr)) |=> done_q && irq && !running)
        else $error("completion did not raise done and irq");

    a_count_held: assert property (@(posedge clk) disable iff (rst)
        (done_q && !running && !startWrite) |=> $stable(found_q))
        else $error("error count changed after completion");

    a_pos_record: assert property (@(posedge clk) disable iff (rst)
        rootHit |=> loc_q[$past(found_q)] == $past(step_q) && found_q == $past(found_q) + 5'h01)
        else $error("root position not recorded");

    a_range_guard: assert property (@(posedge clk) disable iff (rst)
        (running && step_q >= fieldMask) |=> $stable(found_q))
        else $error("root accepted outside the valid range");

    a_root_limit: assert property (@(posedge clk) disable iff (rst)
        found_q <= foundLimit || !running)
        else $error("more roots found than requested");

    a_field_width: assert property (@(posedge clk) disable iff (rst)
        (running && !sectorBig_q) |-> evalSum[13] == 1'b0)
        else $error("term left the small field");

    a_mask_ctrl: assert property (@(posedge clk) disable iff (rst)
        (wrCommit && hitIrqClr && wbReq.dat[0]) |=> !mask_q && !irq)
        else $error("interrupt disable not effective");

    a_start_clears: assert property (@(posedge clk) disable iff (rst)
        startWrite |=> !done_q && !irq)
        else $error("start did not clear completion");

    a_ack_pulse: assert property (@(posedge clk) disable iff (rst)
        (busOn && !ack_q) |=> ack_q ##1 !ack_q)
        else $error("ack not a single-cycle answer");

    a_busy_ends: assert property (@(posedge clk) disable iff (rst)
        finish |=> !running && done_q)
        else $error("busy did not drop at the end of the search");

    a_start_locked: assert property (@(posedge clk) disable iff (rst)
        (wrCommit && hitStart && running) |=> $stable(testCount_q))
        else $error("start write accepted while busy");

    a_mask_set: assert property (@(posedge clk) disable iff (rst)
        (wrCommit && hitIrqSet && wbReq.dat[0]) |=> mask_q)
        else $error("interrupt enable not effective");

    a_locs_cleared: assert property (@(posedge clk) disable iff (rst)
        startWrite |=> loc_q[0] == RESET_FIELD && loc_q[NUM_LOC-1] == RESET_FIELD)
        else $error("positions not cleared at start");

    a_cfg_frozen: assert property (@(posedge clk) disable iff (rst)
        (wrCommit && hitCfg && running) |=> $stable(sectorBig_q) && $stable(expected_error_number_q))
        else $error("configuration changed during a search");

endmodule : belrs_root_search

// *** bench/belrs_root_search_tb_top.sv ***
module belrs_root_search_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import belrs_pkg::*;

    // ------------------------------------------------------------------
    // signals and counters
    // ------------------------------------------------------------------
    logic            clk;
    logic            rst;
    belrs_wbreq_type wbReq;
    logic [31:0]     wbDatOut;
    logic            wbAck;
    logic            irq;
    logic [31:0]     rd;
    int              failCount;
    int              nTests;

`define CHK(nm, ex, gt) begin nTests++; if ((gt) !== (ex)) begin failCount++; \
    $display("BAD %s expected %h seen %h", nm, ex, gt); end end

    belrs_root_search i_dut (
        .clk      (clk),
        .rst      (rst),
        .wbReq    (wbReq),
        .wbDatOut (wbDatOut),
        .wbAck    (wbAck),
        .irq      (irq)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // bus tasks and the closing report
    // ------------------------------------------------------------------
    task automatic closeOut();
        $display("counts: %0d checks, %0d mismatches", nTests, failCount);
        if (failCount == 0 && nTests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : closeOut

    // the request stands until the rising edge at which ack is sampled high; data is taken there
    task automatic xfer(input logic we, input logic [8:0] a, input logic [31:0] d, output logic [31:0] q);
        int k;
        k = 0;
        @(posedge clk);
        wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: a, dat: d};
        do begin
            @(posedge clk);
            k++;
        end while (wbAck !== 1'b1 && k < 50);
        if (wbAck !== 1'b1) begin
            failCount++;
            closeOut();
        end
        q = wbDatOut;
        wbReq.cyc <= 1'b0;
        wbReq.stb <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask : wr

    task automatic rdchk(input logic [8:0] a, input logic [31:0] e, input string nm);
        xfer(1'b0, a, 32'h0000_0000, rd);
        `CHK(nm, e, rd)
    endtask : rdchk

    // starts a search and counts cycles from the commit edge to the rise of irq
    task automatic runSearch(input logic [31:0] cnt, input logic [31:0] stat, input bit fullLen);
        int n;
        n = 0;
        wr(OFF_START, cnt);
        do begin
            @(negedge clk);
            n++;
        end while (irq !== 1'b1 && n < 20000);
        if (irq !== 1'b1) begin
            failCount++;
            closeOut();
        end
        if (fullLen) `CHK("search cycles", cnt, 32'(n - 1))
        rdchk(OFF_STATE, 32'h0000_0000, "busy after end");
        rdchk(OFF_IRQ_STATUS, stat, "done and count");
    endtask : runSearch

    task automatic setCoeffs(input logic [31:0] c0, input logic [31:0] c1, input logic [31:0] c2,
                             input logic [31:0] c24);
        wr(OFF_COEFF_FIRST, c0);
        wr(OFF_COEFF_FIRST + 9'h004, c1);
        wr(OFF_COEFF_FIRST + 9'h008, c2);
        wr(OFF_COEFF_LAST, c24);
    endtask : setCoeffs

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic testReset();
        logic [8:0] regs [7] = '{OFF_CONFIG, OFF_START, OFF_STATE, OFF_IRQ_MASK, OFF_IRQ_STATUS,
                                 OFF_COEFF_LAST, OFF_LOC_LAST};
        foreach (regs[i]) rdchk(regs[i], 32'h0000_0000, "reset value");
        wr(9'h024, 32'hffff_ffff);
        rdchk(9'h024, 32'h0000_0000, "reserved word");
        rdchk(9'h0e8, 32'h0000_0000, "reserved tail");
        `CHK("irq at reset", 1'b0, irq)
        $display("test reset done");
    endtask : testReset

    // sigma = (x + 1)(x + alpha): roots at element 0 and element 1
    task automatic testTwoRoots(input logic big, input logic [31:0] cnt);
        wr(OFF_IRQ_SET, 32'h0000_0001);
        wr(OFF_CONFIG, {31'h0, big});
        rdchk(OFF_PRIMITIVE, {16'h0000, big ? PRIM_LARGE : PRIM_SMALL}, "primitive");
        setCoeffs(32'h0000_0002, 32'h0000_0003, 32'h0000_0001, 32'h0000_0000);
        runSearch(cnt, 32'h0000_0201, 1'b1);
        rdchk(OFF_LOC_FIRST, 32'h0000_0000, "first position");
        rdchk(OFF_LOC_FIRST + 9'h004, 32'h0000_0001, "second position");
        rdchk(OFF_LOC_FIRST + 9'h008, 32'h0000_0000, "unused position");
        $display("test two roots done");
    endtask : testTwoRoots

    // x^24 + 1 in the large field has roots at 0, 5461, 10922; the last lies past the count
    task automatic testTopCoeff();
        wr(OFF_CONFIG, 32'h0000_0001);
        setCoeffs(32'h0000_0001, 32'h0000_0000, 32'h0000_0000, 32'h0000_0001);
        runSearch(32'd8528, 32'h0000_0201, 1'b1);
        rdchk(OFF_LOC_FIRST + 9'h004, 32'h0000_1555, "degree 24 root");
        $display("test degree 24 done");
    endtask : testTopCoeff

    // bit 13 of a coefficient falls outside the small field; 1 + x is zero again
    // at element 8191, which lies outside the valid range and must not count
    task automatic testSmallMask();
        wr(OFF_CONFIG, 32'h0000_0000);
        setCoeffs(32'h0000_2001, 32'h0000_0001, 32'h0000_0000, 32'h0000_0000);
        runSearch(32'd4408, 32'h0000_0101, 1'b1);
        rdchk(OFF_LOC_FIRST, 32'h0000_0000, "masked root");
        runSearch(32'd8200, 32'h0000_0101, 1'b1);
        rdchk(OFF_LOC_FIRST + 9'h004, 32'h0000_0000, "root past valid range");
        $display("test small field mask done");
    endtask : testSmallMask

    task automatic testLimit();
        wr(OFF_CONFIG, 32'h0001_0000);
        setCoeffs(32'h0000_0002, 32'h0000_0003, 32'h0000_0001, 32'h0000_0000);
        runSearch(32'd4200, 32'h0000_0101, 1'b0);
        rdchk(OFF_LOC_FIRST + 9'h004, 32'h0000_0000, "no second root");
        $display("test root limit done");
    endtask : testLimit

    task automatic testIrqMask();
        wr(OFF_IRQ_CLEAR, 32'h0000_0001);
        rdchk(OFF_IRQ_MASK, 32'h0000_0000, "mask cleared");
        `CHK("irq masked", 1'b0, irq)
        wr(OFF_IRQ_SET, 32'h0000_0001);
        rdchk(OFF_IRQ_MASK, 32'h0000_0001, "mask set");
        `CHK("irq unmasked", 1'b1, irq)
        $display("test interrupt mask done");
    endtask : testIrqMask

    // a constant polynomial has no roots, so the search would run its full count
    task automatic testAbort();
        setCoeffs(32'h0000_0001, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
        wr(OFF_START, 32'd4252);
        rdchk(OFF_STATE, 32'h0000_0001, "busy running");
        rdchk(OFF_IRQ_STATUS, 32'h0000_0000, "done cleared");
        `CHK("irq on start", 1'b0, irq)
        wr(OFF_START, 32'h0000_0010);
        rdchk(OFF_START, 32'd4252, "start while busy");
        wr(OFF_STOP, 32'h0000_0001);
        rdchk(OFF_STATE, 32'h0000_0000, "busy after stop");
        repeat (4300) @(negedge clk);
        rdchk(OFF_IRQ_STATUS, 32'h0000_0000, "no done after stop");
        `CHK("irq after stop", 1'b0, irq)
        $display("test abort done");
    endtask : testAbort

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        failCount = 0;
        nTests = 0;
        rst = 1'b1;
        wbReq = '0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        testReset();
        testTwoRoots(1'b0, 32'd4122);
        testTwoRoots(1'b1, 32'd8220);
        testTopCoeff();
        testSmallMask();
        testLimit();
        testIrqMask();
        testAbort();
        closeOut();
    end

endmodule : belrs_root_search_tb_top
